// ===== apb_host.sv
/* apb host model that programs the clock distributor register bank.
   assumes the slave shares clk and samples the bus on its rising edge. */
`timescale 1ns/100ps
module apb_host
  import clkdist_pkg::*;
(
  // clock
  input  wire logic        clk,
  // apb master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  logic [31:0] rdata;
  logic        slverr;
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0000_0000;
  end
  // released address and data lines are inverted so a stale value never looks valid
  task automatic xfer(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata   = prdata;
    slverr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    // let the slave's register updates land before the caller looks
    #1;
  endtask : xfer
  task automatic wr_cfg(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, (a == OFS_OUTPUT0) ? {1'b0, d[30:0]} : d);
  endtask : wr_cfg
  // other fields are sent too; the caller must rewrite register zero
  task automatic soft_reset(input logic [31:0] d);
    xfer(1'b1, OFS_OUTPUT0, {1'b1, d[30:0]});
  endtask : soft_reset
endmodule : apb_host

// ===== clkdist_pkg.sv
/*
 * shared constants for the clock distributor configuration register bank:
 * register byte offsets on the APB, field positions and reset values.
 * assumes a 32-bit APB master with word-aligned byte addresses.
 */
package clkdist_pkg;

  localparam int          NUM_OUTPUTS        = 8;
  localparam logic [11:0] OFS_OUTPUT0        = 12'h000;
  localparam logic [11:0] OFS_LOCK_DETECT    = 12'h02c;
  localparam logic [11:0] OFS_GLOBAL_PLL     = 12'h038;
  localparam logic [11:0] OFS_FEEDBACK_GAIN  = 12'h03c;

  localparam int          SOFT_RESET_POS     = 31;
  localparam int          PATH_SEL_LSB       = 17;
  localparam int          OUT_EN_POS         = 16;
  localparam int          DIVIDER_LSB        = 8;
  localparam int          DELAY_LSB          = 4;
  localparam int          QUARTER_POS        = 15;
  localparam int          GLOBAL_OE_POS      = 27;
  localparam int          SLEEP_POS          = 26;
  localparam int          CP_HIZ_POS         = 25;
  localparam int          CP_POL_POS         = 24;
  localparam int          LOCK_SEL_LSB       = 20;
  localparam int          REF_DIV_LSB        = 8;
  localparam int          FB_DIV_LSB         = 8;
  localparam int          CP_GAIN_LSB        = 30;

  localparam logic [1:0]  PATH_SEL_RST       = 2'h0;
  localparam logic [7:0]  DIVIDER_RST        = 8'h01;
  localparam logic [3:0]  DELAY_RST          = 4'h0;
  localparam logic [3:0]  LOCK_SEL_RST       = 4'h0;
  localparam logic [11:0] REF_DIV_RST        = 12'h00a;
  localparam logic [17:0] FB_DIV_RST         = 18'h002f8;
  localparam logic [1:0]  CP_GAIN_RST        = 2'h0;

endpackage : clkdist_pkg

// ===== clkdist_regs.sv
/*
 * configuration register bank of a PLL clock conditioner, APB slave.
 * assumes an APB master on CLK; fields drive the analog core as plain
 * registered outputs. readback is provided so software can check state.
 */
`timescale 1ns/100ps

// Functional notes
// [R1] eight output control registers, register n drives only clock output n
// [R2] all output registers share one layout; only register zero has reset
// [R3] writing one to bit 31 of register zero restores all defaults
// [R4] a soft-reset write ignores its other fields; host rewrites register zero
// [R5] host writes zero to the soft-reset bit when not using it
// [R6] output path select at bits 18:17, default bypass
// [R7] global output enable at bit 27, default one
// [R8] device sleep at bit 26, default zero
// [R9] charge-pump high impedance at bit 25, default zero
// [R10] charge-pump polarity at bit 24, default negative
// [R11] lock-pin select at bits 23:20, default disabled
// [R12] reference divider at bits 19:8, default ten
// [R13] enable bit 16, divider 15:8 default one, delay 7:4
// [R14] feedback divider 25:8 default 760, gain 31:30, quarter bit 15
module clkdist_regs
  import clkdist_pkg::*;
(
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // per-output controls
  output logic [15:0]      OUTPUT_PATH_SELECT,
  output logic [7:0]       OUTPUT_ENABLE_BIT,
  output logic [63:0]      OUTPUT_DIVIDER_CODE,
  output logic [31:0]      OUTPUT_DELAY_CODE,
  // global and pll controls
  output logic             LOCK_DETECT_QUARTER,
  output logic             GLOBAL_OUTPUT_ENABLE,
  output logic             DEVICE_SLEEP,
  output logic             CHARGE_PUMP_HIZ,
  output logic             CHARGE_PUMP_POLARITY,
  output logic [3:0]       LOCK_PIN_SELECT,
  output logic [11:0]      REF_DIVIDER,
  output logic [17:0]      FEEDBACK_DIVIDER,
  output logic [1:0]       CHARGE_PUMP_GAIN
);

  typedef struct packed {
    logic [1:0] path_sel;
    logic       out_en;
    logic [7:0] divider;
    logic [3:0] delay;
  } out_ctl_t;

  typedef struct packed {
    out_ctl_t [NUM_OUTPUTS-1:0] outs;
    logic                       quarter;
    logic                       global_oe;
    logic                       sleep;
    logic                       cp_hiz;
    logic                       cp_pol;
    logic [3:0]                 lock_sel;
    logic [11:0]                ref_div;
    logic [17:0]                fb_div;
    logic [1:0]                 cp_gain;
    logic [31:0]                rdata;
    logic                       err;
  } state_t;

  localparam out_ctl_t OUT_RST = '{PATH_SEL_RST, 1'b0, DIVIDER_RST, DELAY_RST};

  state_t state_reg;
  state_t state_next;

  // index of an output control register, or -1 when not one
  function automatic int out_index(input logic [11:0] a);
    int idx;
    idx = -1;
    if (a[1:0] == 2'h0 && a[11:5] == 7'h00)
      idx = int'(a[4:2]);
    return idx;
  endfunction : out_index

  function automatic state_t defaults();
    state_t s;
    s           = '0;
    for (int i = 0; i < NUM_OUTPUTS; i++) begin
      s.outs[i] = OUT_RST;                                          // [R13]
    end
    s.global_oe = 1'b1;                                             // [R7]
    s.sleep     = 1'b0;                                             // [R8]
    s.cp_hiz    = 1'b0;                                             // [R9]
    s.cp_pol    = 1'b0;                                             // [R10]
    s.lock_sel  = LOCK_SEL_RST;                                     // [R11]
    s.ref_div   = REF_DIV_RST;                                      // [R12]
    s.fb_div    = FB_DIV_RST;                                       // [R14]
    s.cp_gain   = CP_GAIN_RST;                                      // [R14]
    return s;
  endfunction : defaults

  logic access;
  logic setup;
  logic wr;
  int   oidx;
  logic mapped;

  assign access = PSEL && PENABLE;
  assign setup  = PSEL && !PENABLE;
  assign wr     = access && PWRITE;
  assign oidx   = out_index(PADDR);
  assign mapped = (oidx >= 0) || PADDR == OFS_LOCK_DETECT
                  || PADDR == OFS_GLOBAL_PLL || PADDR == OFS_FEEDBACK_GAIN;

  always_comb begin
    state_next = state_reg;
    // read data is captured in the setup cycle, so PRDATA leaves a
    // flip-flop in the access cycle and still needs no wait state
    if (setup) begin
      state_next.err   = !mapped;
      state_next.rdata = 32'h0;
      if (!PWRITE && oidx >= 0) begin
        state_next.rdata[PATH_SEL_LSB+:2] = state_reg.outs[oidx].path_sel;
        state_next.rdata[OUT_EN_POS]      = state_reg.outs[oidx].out_en;
        state_next.rdata[DIVIDER_LSB+:8]  = state_reg.outs[oidx].divider;
        state_next.rdata[DELAY_LSB+:4]    = state_reg.outs[oidx].delay;
      end else if (!PWRITE && PADDR == OFS_LOCK_DETECT) begin
        state_next.rdata[QUARTER_POS]     = state_reg.quarter;
      end else if (!PWRITE && PADDR == OFS_GLOBAL_PLL) begin
        state_next.rdata[GLOBAL_OE_POS]   = state_reg.global_oe;
        state_next.rdata[SLEEP_POS]       = state_reg.sleep;
        state_next.rdata[CP_HIZ_POS]      = state_reg.cp_hiz;
        state_next.rdata[CP_POL_POS]      = state_reg.cp_pol;
        state_next.rdata[LOCK_SEL_LSB+:4] = state_reg.lock_sel;
        state_next.rdata[REF_DIV_LSB+:12] = state_reg.ref_div;
      end else if (!PWRITE && PADDR == OFS_FEEDBACK_GAIN) begin
        state_next.rdata[FB_DIV_LSB+:18]  = state_reg.fb_div;
        state_next.rdata[CP_GAIN_LSB+:2]  = state_reg.cp_gain;
      end
    end else if (access) begin
      // the read bus goes back to zero once the transfer ends
      state_next.rdata = 32'h0;
      state_next.err   = 1'b0;
    end
    if (wr) begin
      // soft reset drops the rest of the word; host must write again
      if (PADDR == OFS_OUTPUT0 && PWDATA[SOFT_RESET_POS]) begin // [R3] [R4]
        state_next = defaults();
        state_next.err = 1'b0;
      end else if (oidx >= 0) begin                                 // [R1] [R2]
        state_next.outs[oidx].path_sel = PWDATA[PATH_SEL_LSB+:2];   // [R6]
        state_next.outs[oidx].out_en   = PWDATA[OUT_EN_POS];        // [R13]
        state_next.outs[oidx].divider  = PWDATA[DIVIDER_LSB+:8];    // [R13]
        state_next.outs[oidx].delay    = PWDATA[DELAY_LSB+:4];      // [R13]
      end else if (PADDR == OFS_LOCK_DETECT) begin
        state_next.quarter   = PWDATA[QUARTER_POS];                 // [R14]
      end else if (PADDR == OFS_GLOBAL_PLL) begin
        state_next.global_oe = PWDATA[GLOBAL_OE_POS];               // [R7]
        state_next.sleep     = PWDATA[SLEEP_POS];                   // [R8]
        state_next.cp_hiz    = PWDATA[CP_HIZ_POS];                  // [R9]
        state_next.cp_pol    = PWDATA[CP_POL_POS];                  // [R10]
        state_next.lock_sel  = PWDATA[LOCK_SEL_LSB+:4];             // [R11]
        state_next.ref_div   = PWDATA[REF_DIV_LSB+:12];             // [R12]
      end else if (PADDR == OFS_FEEDBACK_GAIN) begin
        state_next.fb_div    = PWDATA[FB_DIV_LSB+:18];              // [R14]
        state_next.cp_gain   = PWDATA[CP_GAIN_LSB+:2];              // [R14]
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      state_reg <= defaults();
    end else begin
      state_reg <= state_next;
    end
  end

  // zero wait states: the access phase always completes at once; the
  // address is held from setup, so the word fetched then is still right
  assign PREADY  = 1'b1;
  assign PRDATA  = state_reg.rdata;
  assign PSLVERR = access && state_reg.err;

  genvar g;
  generate
    for (g = 0; g < NUM_OUTPUTS; g++) begin : g_out
      assign OUTPUT_PATH_SELECT[2*g+:2]  = state_reg.outs[g].path_sel; // [R1]
      assign OUTPUT_ENABLE_BIT[g]        = state_reg.outs[g].out_en;
      assign OUTPUT_DIVIDER_CODE[8*g+:8] = state_reg.outs[g].divider;
      assign OUTPUT_DELAY_CODE[4*g+:4]   = state_reg.outs[g].delay;
      // a write to register n that is not a soft reset may touch output n and no other
      AST_OUT_ONLY_OWN: assert property (@(posedge CLK) // [R1]
        disable iff (!RST_B)
        wr && oidx >= 0 && oidx != g
          && !(oidx == 0 && PWDATA[SOFT_RESET_POS]) |=>
          $stable({OUTPUT_PATH_SELECT[2*g+:2], OUTPUT_ENABLE_BIT[g],
                   OUTPUT_DIVIDER_CODE[8*g+:8], OUTPUT_DELAY_CODE[4*g+:4]}))
        else $error("a write to one output changed another");
    end
  endgenerate

  assign LOCK_DETECT_QUARTER  = state_reg.quarter;
  assign GLOBAL_OUTPUT_ENABLE = state_reg.global_oe;
  assign DEVICE_SLEEP         = state_reg.sleep;
  assign CHARGE_PUMP_HIZ      = state_reg.cp_hiz;
  assign CHARGE_PUMP_POLARITY = state_reg.cp_pol;
  assign LOCK_PIN_SELECT      = state_reg.lock_sel;
  assign REF_DIVIDER          = state_reg.ref_div;
  assign FEEDBACK_DIVIDER     = state_reg.fb_div;
  assign CHARGE_PUMP_GAIN     = state_reg.cp_gain;

  AST_SOFT_RESET: assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
    wr && PADDR == OFS_OUTPUT0 && PWDATA[SOFT_RESET_POS] |=>
      GLOBAL_OUTPUT_ENABLE && REF_DIVIDER == REF_DIV_RST
      && FEEDBACK_DIVIDER == FB_DIV_RST && OUTPUT_DIVIDER_CODE[7:0] == 8'h01)
    else $error("soft reset did not restore defaults");
  AST_RESET_IGNORES: assert property (@(posedge CLK) // [R4]
    disable iff (!RST_B)
    wr && PADDR == OFS_OUTPUT0 && PWDATA[SOFT_RESET_POS] |=>
      OUTPUT_PATH_SELECT[1:0] == 2'h0 && !OUTPUT_ENABLE_BIT[0])
    else $error("soft reset write applied its other fields");
  AST_OUT_ISOLATE: assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
    wr && oidx > 0 |=> $stable(OUTPUT_DIVIDER_CODE[7:0]))
    else $error("write to another output changed output zero");
  AST_PATH_SEL: assert property (@(posedge CLK) disable iff (!RST_B) // [R6]
    wr && PADDR == 12'h004 |=> OUTPUT_PATH_SELECT[3:2] == $past(PWDATA[18:17]))
    else $error("path select not stored");
  AST_GLOBAL_OE: assert property (@(posedge CLK) disable iff (!RST_B) // [R7]
    wr && PADDR == OFS_GLOBAL_PLL |=>
      GLOBAL_OUTPUT_ENABLE == $past(PWDATA[27]))
    else $error("global output enable not stored");
  AST_SLEEP: assert property (@(posedge CLK) disable iff (!RST_B) // [R8]
    !(wr && PADDR == OFS_GLOBAL_PLL) && !(wr && PADDR == OFS_OUTPUT0)
      |=> $stable(DEVICE_SLEEP))
    else $error("sleep changed without a write");
  AST_REF_DIV: assert property (@(posedge CLK) disable iff (!RST_B) // [R12]
    wr && PADDR == OFS_GLOBAL_PLL |=> REF_DIVIDER == $past(PWDATA[19:8]))
    else $error("reference divider not stored");
  AST_FB_DIV: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
    wr && PADDR == OFS_FEEDBACK_GAIN |=>
      FEEDBACK_DIVIDER == $past(PWDATA[25:8])
      && CHARGE_PUMP_GAIN == $past(PWDATA[31:30]))
    else $error("feedback divider or gain not stored");

  // global and output fields are stored from their own bit positions; soft reset returns the globals to their defaults
  AST_SLEEP_STORE: assert property (@(posedge CLK) disable iff (!RST_B) // [R8]
    wr && PADDR == OFS_GLOBAL_PLL |=> DEVICE_SLEEP == $past(PWDATA[SLEEP_POS]))
    else $error("device sleep not stored");
  AST_CP_HIZ: assert property (@(posedge CLK) disable iff (!RST_B) // [R9]
    wr && PADDR == OFS_GLOBAL_PLL |=>
      CHARGE_PUMP_HIZ == $past(PWDATA[CP_HIZ_POS]))
    else $error("charge pump high impedance bit not stored");
  AST_CP_POL: assert property (@(posedge CLK) disable iff (!RST_B) // [R10]
    wr && PADDR == OFS_GLOBAL_PLL |=>
      CHARGE_PUMP_POLARITY == $past(PWDATA[CP_POL_POS]))
    else $error("charge pump polarity not stored");
  AST_LOCK_SEL: assert property (@(posedge CLK) disable iff (!RST_B) // [R11]
    wr && PADDR == OFS_GLOBAL_PLL |=>
      LOCK_PIN_SELECT == $past(PWDATA[LOCK_SEL_LSB+:4]))
    else $error("lock pin select not stored");
  AST_QUARTER: assert property (@(posedge CLK) disable iff (!RST_B) // [R14]
    wr && PADDR == OFS_LOCK_DETECT |=>
      LOCK_DETECT_QUARTER == $past(PWDATA[QUARTER_POS]))
    else $error("lock detect quarter bit not stored");
  AST_OUT_FIELDS: assert property (@(posedge CLK) disable iff (!RST_B) // [R13]
    wr && PADDR == OFS_OUTPUT0 && !PWDATA[SOFT_RESET_POS] |=>
      OUTPUT_ENABLE_BIT[0] == $past(PWDATA[OUT_EN_POS])
      && OUTPUT_DIVIDER_CODE[7:0] == $past(PWDATA[DIVIDER_LSB+:8])
      && OUTPUT_DELAY_CODE[3:0] == $past(PWDATA[DELAY_LSB+:4]))
    else $error("output zero fields not stored");
  AST_PATH_SEL7: assert property (@(posedge CLK) disable iff (!RST_B) // [R6]
    wr && PADDR == 12'h01c |=>
      OUTPUT_PATH_SELECT[15:14] == $past(PWDATA[PATH_SEL_LSB+:2]))
    else $error("last output path select not stored");
  AST_SOFT_GLOBAL: assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
    wr && PADDR == OFS_OUTPUT0 && PWDATA[SOFT_RESET_POS] |=>
      !DEVICE_SLEEP && !CHARGE_PUMP_HIZ && !CHARGE_PUMP_POLARITY
      && !LOCK_DETECT_QUARTER && LOCK_PIN_SELECT == LOCK_SEL_RST
      && CHARGE_PUMP_GAIN == CP_GAIN_RST)
    else $error("soft reset left a global field changed");

  // bus side: error response, readback layout, unmapped writes
  AST_SLVERR: assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
    access |-> PSLVERR == !mapped)
    else $error("error response does not match the address map");
  AST_READBACK: assert property (@(posedge CLK) disable iff (!RST_B) // [R2]
    access && !PWRITE && PADDR == 12'h01c |->
      PRDATA[18:4] == {OUTPUT_PATH_SELECT[15:14], OUTPUT_ENABLE_BIT[7],
                       OUTPUT_DIVIDER_CODE[63:56], OUTPUT_DELAY_CODE[31:28]}
      && PRDATA[31:19] == 13'h0 && PRDATA[3:0] == 4'h0)
    else $error("output seven reads back a different layout");
  AST_SOFT_CLEARS: assert property (@(posedge CLK) disable iff (!RST_B) // [R3]
    access && !PWRITE && PADDR == OFS_OUTPUT0 |-> !PRDATA[SOFT_RESET_POS])
    else $error("soft reset bit reads back as set");
  AST_UNMAPPED: assert property (@(posedge CLK) disable iff (!RST_B) // [R1]
    wr && !mapped |=>
      $stable({OUTPUT_PATH_SELECT, OUTPUT_ENABLE_BIT, OUTPUT_DIVIDER_CODE,
               GLOBAL_OUTPUT_ENABLE, REF_DIVIDER, FEEDBACK_DIVIDER}))
    else $error("write to an unmapped address changed a register");

  COV_SOFT_RESET: cover property (@(posedge CLK) disable iff (!RST_B)
    wr && PADDR == OFS_OUTPUT0 && PWDATA[SOFT_RESET_POS]);
  COV_OUT7: cover property (@(posedge CLK) disable iff (!RST_B)
    wr && PADDR == 12'h01c);
  COV_BADADDR: cover property (@(posedge CLK) disable iff (!RST_B)
    access && !mapped);
  COV_READBACK: cover property (@(posedge CLK) disable iff (!RST_B)
    access && !PWRITE && PADDR == OFS_GLOBAL_PLL);

endmodule : clkdist_regs

// ===== tb_top.sv
/* self-checking bench for the clock distributor register bank.
   assumes apb_host is the only source of bus traffic. */
`timescale 1ns/100ps
module tb_top
  import clkdist_pkg::*;
;
  typedef struct packed {logic [11:0] a; logic [31:0] w, r; logic e;} row_t;
  localparam logic [160:0] DFLT = {16'h0, 8'h0, {8{8'h01}}, 32'h0,
    5'b01000, 4'h0, 12'h00a, 18'd760, 2'h0};
  logic        clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] path;
  logic [7:0]  oen;
  logic [63:0] divc;
  logic [31:0] dlyc;
  logic        quarter, goe, sleep, hiz, pol;
  logic [3:0]  lsel;
  logic [11:0] rdiv;
  logic [17:0] fdiv;
  logic [1:0]  gain;
  int          err_total, tests_run, cycles;
  row_t        rows [12];
  wire [160:0] outs = {path, oen, divc, dlyc, quarter, goe, sleep, hiz,
                       pol, lsel, rdiv, fdiv, gain};

  clkdist_regs u_clkdist_regs (.CLK(clk), .RST_B(rst_b), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .OUTPUT_PATH_SELECT(path), .OUTPUT_ENABLE_BIT(oen),
    .OUTPUT_DIVIDER_CODE(divc), .OUTPUT_DELAY_CODE(dlyc),
    .LOCK_DETECT_QUARTER(quarter), .GLOBAL_OUTPUT_ENABLE(goe),
    .DEVICE_SLEEP(sleep), .CHARGE_PUMP_HIZ(hiz),
    .CHARGE_PUMP_POLARITY(pol), .LOCK_PIN_SELECT(lsel),
    .REF_DIVIDER(rdiv), .FEEDBACK_DIVIDER(fdiv), .CHARGE_PUMP_GAIN(gain));
  apb_host u_apb_host (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [160:0] seen, input logic [160:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    u_apb_host.xfer(1'b0, a, 32'h0000_0000);
    chk(u_apb_host.rdata, exp);
  endtask : rd
  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  // ceiling of 3000 cycles is about 26 times the expected run length of some 115 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      give_verdict();
    end
  end

  initial begin
    rst_b = 1'b0;
    err_total = 0;
    tests_run = 0;
    cycles = 0;
    rows = '{'{12'h000, 32'h7fff_ffff, 32'h0007_fff0, 1'b0},
             '{12'h004, 32'h0002_3450, 32'h0002_3450, 1'b0},
             '{12'h008, 32'h0004_1230, 32'h0004_1230, 1'b0},
             '{12'h00c, 32'h0006_0010, 32'h0006_0010, 1'b0},
             '{12'h010, 32'h0001_ff00, 32'h0001_ff00, 1'b0},
             '{12'h014, 32'hf000_000f, 32'h0000_0000, 1'b0},
             '{12'h018, 32'h0005_80f0, 32'h0005_80f0, 1'b0},
             '{12'h01c, 32'h0003_aa70, 32'h0003_aa70, 1'b0},
             '{12'h02c, 32'hffff_ffff, 32'h0000_8000, 1'b0},
             '{12'h038, 32'hffff_ffff, 32'h0fff_ff00, 1'b0},
             '{12'h03c, 32'hffff_ffff, 32'hc3ff_ff00, 1'b0},
             '{12'h030, 32'hffff_ffff, 32'h0000_0000, 1'b1}};
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    chk(outs, DFLT);
    rd(OFS_OUTPUT0, 32'h0000_0100);
    rd(OFS_GLOBAL_PLL, 32'h0800_0a00);
    rd(OFS_FEEDBACK_GAIN, 32'h0002_f800);
    $display("reset defaults test done");
    foreach (rows[i]) begin
      u_apb_host.wr_cfg(rows[i].a, rows[i].w);
      chk(u_apb_host.slverr, rows[i].e);
      rd(rows[i].a, rows[i].r);
      chk(u_apb_host.slverr, rows[i].e);
    end
    for (int n = 0; n < 8; n++) begin
      chk({path[2*n+:2], oen[n], divc[8*n+:8], dlyc[4*n+:4]},
          rows[n].r[18:4]);
    end
    chk(outs[40:0], {41{1'b1}});
    $display("register table test done");
    u_apb_host.soft_reset(32'h0007_fff0);
    chk(outs, DFLT);
    rd(OFS_OUTPUT0, 32'h0000_0100);
    u_apb_host.wr_cfg(OFS_OUTPUT0, rows[1].w);
    chk({path[1:0], divc[7:0]}, {rows[1].w[18:17], rows[1].w[15:8]});
    $display("soft reset test done");
    u_apb_host.wr_cfg(OFS_GLOBAL_PLL, 32'h0000_0000);
    chk({goe, rdiv}, 13'h0);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1 chk(outs, DFLT);
    @(posedge clk);
    rst_b <= 1'b1;
    rd(OFS_GLOBAL_PLL, 32'h0800_0a00);
    $display("hard reset test done");
    give_verdict();
  end
endmodule : tb_top
